/* hw/lpm_regs.vh */
// register map, field positions, reset values and timing for measure control
`ifndef LPM_REGS_VH
`define LPM_REGS_VH

// register addresses
`define LPM_ADDR_CMD 8'h80
`define LPM_ADDR_ID 8'h81
`define LPM_ADDR_RATE 8'h82
`define LPM_ADDR_AMB_HI 8'h85
`define LPM_ADDR_AMB_LO 8'h86
`define LPM_ADDR_PROX_HI 8'h87
`define LPM_ADDR_PROX_LO 8'h88

// command register field positions
`define LPM_CMD_LOCK 7
`define LPM_CMD_AMB_VALID 6
`define LPM_CMD_PROX_VALID 5
`define LPM_CMD_AMB_TRIG 4
`define LPM_CMD_PROX_TRIG 3
`define LPM_CMD_AMB_EN 2
`define LPM_CMD_PROX_EN 1
`define LPM_CMD_SELFTIMED 0

// rate register field
`define LPM_RATE_MSB 2
`define LPM_RATE_LSB 0
`define LPM_RATE_W 3

// identification fields
`define LPM_ID_PROD_MSB 7
`define LPM_ID_PROD_LSB 4
`define LPM_ID_REV_MSB 3
`define LPM_ID_REV_LSB 0

// reset values
`define LPM_CMD_RESET 8'h80
`define LPM_RATE_RESET 3'h0
`define LPM_LOCK_VALUE 1'b1
`define LPM_UNMAPPED_READ 8'h00

// timing: one conversion step, clock rate in kHz
`define LPM_CLK_KHZ 10000
`define LPM_CONV_TIME_US 100
`define LPM_CONV_CYCLES ((`LPM_CONV_TIME_US * `LPM_CLK_KHZ + 999) / 1000)
// slowest proximity period and periodic ambient period, in cycles
`define LPM_RATE_BASE_CYCLES 4194304
`define LPM_AMB_PERIOD_CYCLES 1000000

`endif

/* hw/lpm_conv.v */
// one conversion channel with optional power-of-two averaging
`timescale 1ns/1ns
`include "lpm_regs.vh"

module lpm_conv #(
	parameter DATA_W = 16,
	parameter AVG_W = 3,
	parameter CONV_CYCLES = `LPM_CONV_CYCLES
) (
	// clock and reset
	input wire mclk,
	input wire arst_n,
	// control
	input wire start,
	input wire [AVG_W-1:0] avg_sel,
	// front end sample, valid at end of each step
	input wire [DATA_W-1:0] sample,
	// status and result
	output reg busy,
	output reg done,
	output reg [DATA_W-1:0] result
);

	localparam ACC_W = DATA_W + (1 << AVG_W) - 1;
	localparam CNT_W = 16;
	localparam [31:0] STEP_FULL = CONV_CYCLES - 1;
	localparam [CNT_W-1:0] STEP_LAST = STEP_FULL[CNT_W-1:0];

	reg [CNT_W-1:0] step_reg;
	reg [(1 << AVG_W)-1:0] left_reg;
	reg [AVG_W-1:0] shift_reg;
	reg [ACC_W-1:0] acc_reg;
	wire [ACC_W-1:0] acc_sum;
	wire [ACC_W-1:0] acc_avg;

	assign acc_sum = acc_reg + {{(ACC_W-DATA_W){1'b0}}, sample};
	assign acc_avg = acc_sum >> shift_reg;

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
			done <= 1'b0;
			result <= {DATA_W{1'b0}};
			step_reg <= {CNT_W{1'b0}};
			left_reg <= {(1 << AVG_W){1'b0}};
			shift_reg <= {AVG_W{1'b0}};
			acc_reg <= {ACC_W{1'b0}};
		end else begin
			done <= 1'b0;
			if (!busy) begin
				// a start during a running conversion is dropped
				if (start) begin
					busy <= 1'b1;
					step_reg <= {CNT_W{1'b0}};
					left_reg <= ({{((1 << AVG_W)-1){1'b0}}, 1'b1} << avg_sel)
						- 1'b1;
					shift_reg <= avg_sel;
					acc_reg <= {ACC_W{1'b0}};
				end
			end else if (step_reg == STEP_LAST) begin
				step_reg <= {CNT_W{1'b0}};
				if (left_reg == {(1 << AVG_W){1'b0}}) begin
					busy <= 1'b0;
					done <= 1'b1;
					result <= acc_avg[DATA_W-1:0];
				end else begin
					left_reg <= left_reg - 1'b1;
					acc_reg <= acc_sum;
				end
			end else begin
				step_reg <= step_reg + 1'b1;
			end
		end
	end

endmodule // lpm_conv

/* hw/lpm_ctrl.v */
// measurement command, identification and proximity rate control
`timescale 1ns/1ns
`include "lpm_regs.vh"

// Behaviour
// - proximity valid set on result, cleared on read
// - ambient trigger runs one, optionally averaged, conversion
// - proximity trigger runs one proximity conversion
// - self-timed bit starts state machine and oscillator
// - periodic conversions need their own enable too
// - both triggers in one write run together
// - triggers ignored while self-timed is set
// - rate register low three bits, upper unused
// - new rate applies after self-timed is cycled
// - identification read-only: product and revision nibbles
// - ambient valid set on result, cleared on read
// - command register bit layout as documented
module lpm_ctrl #(
	parameter DATA_W = 16,
	parameter AVG_W = 3,
	// identification values are arbitrary
	parameter [3:0] PRODUCT_CODE = 4'h5,
	parameter [3:0] REVISION_CODE = 4'h3,
	parameter CONV_CYCLES = `LPM_CONV_CYCLES,
	parameter RATE_BASE_CYCLES = `LPM_RATE_BASE_CYCLES,
	parameter AMB_PERIOD_CYCLES = `LPM_AMB_PERIOD_CYCLES
) (
	// clock and reset
	input wire mclk,
	input wire arst_n,
	// register port
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	// front end
	input wire [DATA_W-1:0] ambient_sample,
	input wire [DATA_W-1:0] proximity_sample,
	input wire [AVG_W-1:0] ambient_avg_sel,
	// status and results
	output reg low_power_osc_en,
	output reg ambient_busy,
	output reg proximity_busy,
	output reg [DATA_W-1:0] ambient_result,
	output reg [DATA_W-1:0] proximity_result
);

	localparam CNT_W = 32;
	localparam [CNT_W-1:0] AMB_LAST = AMB_PERIOD_CYCLES - 1;

	// command register fields
	reg selftimed_reg;
	reg amb_en_reg;
	reg prox_en_reg;
	reg ambient_single_trigger_reg;
	reg proximity_single_trigger_reg;
	reg amb_valid_reg;
	reg prox_valid_reg;
	// rate as written and rate in use
	reg [`LPM_RATE_W-1:0] rate_reg;
	reg [`LPM_RATE_W-1:0] rate_live_reg;
	reg selftimed_dly_reg;
	// periodic dividers
	reg [CNT_W-1:0] amb_cnt_reg;
	reg [CNT_W-1:0] prox_cnt_reg;
	reg [7:0] rdata_next;

	wire amb_busy_w;
	wire prox_busy_w;
	wire amb_done_w;
	wire prox_done_w;
	wire [DATA_W-1:0] amb_res_w;
	wire [DATA_W-1:0] prox_res_w;

	wire wr_cmd;
	wire wr_rate;
	wire rd_amb;
	wire rd_prox;
	wire od_allowed;
	wire amb_od_start;
	wire proximity_single_trigger_start;
	wire amb_run;
	wire prox_run;
	wire amb_tick;
	wire prox_tick;
	wire [CNT_W-1:0] prox_last;

	// decode used for both read strobes and write strobes
	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// slowest rate at code zero, each code step doubles the rate
	function [CNT_W-1:0] rate_period;
		input [`LPM_RATE_W-1:0] code;
		reg [CNT_W-1:0] base;
		begin
			base = RATE_BASE_CYCLES;
			rate_period = (base >> code) - 1'b1;
		end
	endfunction

	assign wr_cmd = reg_wr && hit(reg_addr, `LPM_ADDR_CMD);
	assign wr_rate = reg_wr && hit(reg_addr, `LPM_ADDR_RATE);
	assign rd_amb = reg_rd && (hit(reg_addr, `LPM_ADDR_AMB_HI) ||
		hit(reg_addr, `LPM_ADDR_AMB_LO));
	assign rd_prox = reg_rd && (hit(reg_addr, `LPM_ADDR_PROX_HI) ||
		hit(reg_addr, `LPM_ADDR_PROX_LO));

	// the same write may switch self-timed on; triggers are then dropped
	assign od_allowed = wr_cmd && !selftimed_reg &&
		!reg_wdata[`LPM_CMD_SELFTIMED];
	assign amb_od_start = od_allowed && reg_wdata[`LPM_CMD_AMB_TRIG] &&
		!ambient_single_trigger_reg && !amb_busy_w;
	assign proximity_single_trigger_start = od_allowed && reg_wdata[`LPM_CMD_PROX_TRIG] &&
		!proximity_single_trigger_reg && !prox_busy_w;

	// periodic streams need both the self-timed and their own enable
	assign amb_run = selftimed_reg && amb_en_reg;
	assign prox_run = selftimed_reg && prox_en_reg;
	assign prox_last = rate_period(rate_live_reg);
	// first periodic conversion is taken right at enable
	assign amb_tick = amb_run && (amb_cnt_reg == {CNT_W{1'b0}}) &&
		!amb_busy_w;
	assign prox_tick = prox_run && (prox_cnt_reg == {CNT_W{1'b0}}) &&
		!prox_busy_w;

	lpm_conv #(
		.DATA_W(DATA_W),
		.AVG_W(AVG_W),
		.CONV_CYCLES(CONV_CYCLES)
	) u_amb_conv (
		.mclk(mclk),
		.arst_n(arst_n),
		.start(amb_od_start || amb_tick),
		.avg_sel(ambient_avg_sel),
		.sample(ambient_sample),
		.busy(amb_busy_w),
		.done(amb_done_w),
		.result(amb_res_w)
	);

	lpm_conv #(
		.DATA_W(DATA_W),
		.AVG_W(AVG_W),
		.CONV_CYCLES(CONV_CYCLES)
	) u_prox_conv (
		.mclk(mclk),
		.arst_n(arst_n),
		.start(proximity_single_trigger_start || prox_tick),
		.avg_sel({AVG_W{1'b0}}),
		.sample(proximity_sample),
		.busy(prox_busy_w),
		.done(prox_done_w),
		.result(prox_res_w)
	);

	// command register
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			selftimed_reg <= 1'b0;
			amb_en_reg <= 1'b0;
			prox_en_reg <= 1'b0;
			ambient_single_trigger_reg <= 1'b0;
			proximity_single_trigger_reg <= 1'b0;
			amb_valid_reg <= 1'b0;
			prox_valid_reg <= 1'b0;
		end else begin
			if (wr_cmd) begin
				selftimed_reg <= reg_wdata[`LPM_CMD_SELFTIMED];
				amb_en_reg <= reg_wdata[`LPM_CMD_AMB_EN];
				prox_en_reg <= reg_wdata[`LPM_CMD_PROX_EN];
			end
			// trigger reads one until its conversion is done
			if (amb_od_start) begin
				ambient_single_trigger_reg <= 1'b1;
			end else if (amb_done_w) begin
				ambient_single_trigger_reg <= 1'b0;
			end
			if (proximity_single_trigger_start) begin
				proximity_single_trigger_reg <= 1'b1;
			end else if (prox_done_w) begin
				proximity_single_trigger_reg <= 1'b0;
			end
			// a fresh result beats a read in the same cycle
			if (amb_done_w) begin
				amb_valid_reg <= 1'b1;
			end else if (rd_amb) begin
				amb_valid_reg <= 1'b0;
			end
			if (prox_done_w) begin
				prox_valid_reg <= 1'b1;
			end else if (rd_prox) begin
				prox_valid_reg <= 1'b0;
			end
		end
	end

	// rate register; the live copy is taken only when self-timed starts,
	// so the oscillator side never sees a value change under it
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rate_reg <= `LPM_RATE_RESET;
			rate_live_reg <= `LPM_RATE_RESET;
			selftimed_dly_reg <= 1'b0;
		end else begin
			selftimed_dly_reg <= selftimed_reg;
			if (wr_rate)
				rate_reg <= reg_wdata[`LPM_RATE_MSB:`LPM_RATE_LSB];
			if (selftimed_reg && !selftimed_dly_reg)
				rate_live_reg <= rate_reg;
		end
	end

	// periodic dividers, cleared whenever their stream is off
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			amb_cnt_reg <= {CNT_W{1'b0}};
			prox_cnt_reg <= {CNT_W{1'b0}};
		end else begin
			if (!amb_run)
				amb_cnt_reg <= {CNT_W{1'b0}};
			else if (amb_cnt_reg == AMB_LAST)
				amb_cnt_reg <= {CNT_W{1'b0}};
			else if (amb_cnt_reg != {CNT_W{1'b0}} || amb_tick)
				amb_cnt_reg <= amb_cnt_reg + 1'b1;
			if (!prox_run)
				prox_cnt_reg <= {CNT_W{1'b0}};
			else if (prox_cnt_reg >= prox_last)
				prox_cnt_reg <= {CNT_W{1'b0}};
			else if (prox_cnt_reg != {CNT_W{1'b0}} || prox_tick)
				prox_cnt_reg <= prox_cnt_reg + 1'b1;
		end
	end

	// read data, status outputs and result copies
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= `LPM_UNMAPPED_READ;
			low_power_osc_en <= 1'b0;
			ambient_busy <= 1'b0;
			proximity_busy <= 1'b0;
			ambient_result <= {DATA_W{1'b0}};
			proximity_result <= {DATA_W{1'b0}};
		end else begin
			low_power_osc_en <= selftimed_reg;
			ambient_busy <= amb_busy_w;
			proximity_busy <= prox_busy_w;
			if (amb_done_w) begin
				ambient_result <= amb_res_w;
			end
			if (prox_done_w) begin
				proximity_result <= prox_res_w;
			end
			// byte frozen at the read strobe, so the host sees one
			// consistent value even if a result lands a cycle later
			if (reg_rd) begin
				reg_rdata <= rdata_next;
			end
		end
	end

	// read data of the addressed register
	// unmapped addresses read zero so a bus scan finds no ghosts
	always @* begin
		case (reg_addr)
		`LPM_ADDR_CMD: begin
			rdata_next = {`LPM_LOCK_VALUE, amb_valid_reg, prox_valid_reg,
				ambient_single_trigger_reg, proximity_single_trigger_reg,
				amb_en_reg, prox_en_reg, selftimed_reg};
		end
		`LPM_ADDR_ID: begin
			rdata_next = {PRODUCT_CODE, REVISION_CODE};
		end
		`LPM_ADDR_RATE: begin
			rdata_next = {5'h00, rate_reg};
		end
		`LPM_ADDR_AMB_HI: begin
			rdata_next = ambient_result[15:8];
		end
		`LPM_ADDR_AMB_LO: begin
			rdata_next = ambient_result[7:0];
		end
		`LPM_ADDR_PROX_HI: begin
			rdata_next = proximity_result[15:8];
		end
		`LPM_ADDR_PROX_LO: begin
			rdata_next = proximity_result[7:0];
		end
		default: begin
			rdata_next = `LPM_UNMAPPED_READ;
		end
		endcase
	end

endmodule // lpm_ctrl

/* verif/lpm_ctrl_props.sv */
// assertion checker for the measure control block
`timescale 1ns/1ns
module lpm_ctrl_props #(
	parameter DATA_W = 16,
	parameter AVG_W = 3,
	parameter [3:0] PRODUCT_CODE = 4'h5,
	parameter [3:0] REVISION_CODE = 4'h3
) (
	// clock and reset
	input logic mclk,
	input logic arst_n,
	// register port
	input logic [7:0] reg_addr,
	input logic reg_wr,
	input logic reg_rd,
	input logic [7:0] reg_wdata,
	input logic [7:0] reg_rdata,
	// front end
	input logic [DATA_W-1:0] ambient_sample,
	input logic [DATA_W-1:0] proximity_sample,
	input logic [AVG_W-1:0] ambient_avg_sel,
	// status and results
	input logic low_power_osc_en,
	input logic ambient_busy,
	input logic proximity_busy,
	input logic [DATA_W-1:0] ambient_result,
	input logic [DATA_W-1:0] proximity_result
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	wire cmd_wr = reg_wr && reg_addr == 8'h80;
	wire idle = !ambient_busy && !proximity_busy;
	property p_osc;
		cmd_wr |=> ##1 low_power_osc_en == $past(reg_wdata[0], 2);
	endproperty
	a_osc: assert property (p_osc) else $error("osc lag");
	property p_id;
		reg_rd && reg_addr == 8'h81 |=>
			reg_rdata == {PRODUCT_CODE, REVISION_CODE};
	endproperty
	a_id: assert property (p_id) else $error("id value");
	property p_unmapped;
		reg_rd && (reg_addr > 8'h88 || reg_addr < 8'h80) |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped");
	property p_rate;
		reg_rd && reg_addr == 8'h82 && $past(reg_wr && reg_addr == 8'h82, 2)
			|=> reg_rdata == {5'h00, $past(reg_wdata[2:0], 3)};
	endproperty
	a_rate: assert property (p_rate) else $error("rate field");
	// a write that sets self-timed must not start on-demand work
	property p_no_trig;
		!low_power_osc_en && idle && !$past(reg_wr) && cmd_wr && reg_wdata[0]
			&& reg_wdata[2:1] == 2'b00 |=> idle [*6];
	endproperty
	a_no_trig: assert property (p_no_trig) else $error("trigger run");
	property p_start;
		!low_power_osc_en && idle && !$past(reg_wr) && cmd_wr
			&& reg_wdata == 8'h08 |-> ##[1:3] proximity_busy;
	endproperty
	a_start: assert property (p_start) else $error("no start");
	// at least three cycles long for any step count of three or more
	property p_len;
		$rose(proximity_busy) |-> proximity_busy [*3];
	endproperty
	a_len: assert property (p_len) else $error("short busy");
	property p_hold;
		!proximity_busy ##1 !proximity_busy |-> $stable(proximity_result);
	endproperty
	a_hold: assert property (p_hold) else $error("result moved");
	c_both: cover property (ambient_busy && proximity_busy);
	c_timed: cover property (low_power_osc_en && proximity_busy);
	c_avg: cover property (ambient_busy && ambient_avg_sel != 0);
endmodule // lpm_ctrl_props

bind lpm_ctrl lpm_ctrl_props #(.DATA_W(DATA_W), .AVG_W(AVG_W),
	.PRODUCT_CODE(PRODUCT_CODE), .REVISION_CODE(REVISION_CODE))
	i_lpm_ctrl_props (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .ambient_sample(ambient_sample),
	.proximity_sample(proximity_sample), .ambient_avg_sel(ambient_avg_sel),
	.low_power_osc_en(low_power_osc_en), .ambient_busy(ambient_busy),
	.proximity_busy(proximity_busy), .ambient_result(ambient_result),
	.proximity_result(proximity_result));

/* verif/lpm_host.sv */
// host model driving the register port
`timescale 1ns/1ns
module lpm_host (
	// clock
	input wire logic mclk,
	// register port
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	int gap = 0;
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// callers keep self-timed off around rate writes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		// stale data would hide a late capture
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule // lpm_host

/* verif/lpm_ctrl_tb_top.sv */
// self-checking bench for the measure control block
`timescale 1ns/1ns
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
	mismatches++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module lpm_ctrl_tb_top;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [15:0] amb_s = 16'h0000;
	logic [15:0] prox_s = 16'h0000;
	logic [2:0] avg = 3'h0;
	wire [7:0] reg_addr;
	wire [7:0] reg_wdata;
	wire [7:0] reg_rdata;
	wire reg_wr;
	wire reg_rd;
	wire osc;
	wire amb_b;
	wire prox_b;
	wire [15:0] amb_r;
	wire [15:0] prox_r;
	logic [7:0] d;
	logic [7:0] m;
	logic seen;
	integer seed = 32'hc5fd;
	int mismatches = 0;
	int total_checks = 0;
	int i;
	int c;
	int p;
	always #50 mclk = ~mclk;
	lpm_ctrl #(.CONV_CYCLES(4), .RATE_BASE_CYCLES(64), .AMB_PERIOD_CYCLES(40))
	i_lpm_ctrl (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .ambient_sample(amb_s),
		.proximity_sample(prox_s), .ambient_avg_sel(avg),
		.low_power_osc_en(osc), .ambient_busy(amb_b), .proximity_busy(prox_b),
		.ambient_result(amb_r), .proximity_result(prox_r));
	lpm_host i_lpm_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	function automatic logic [7:0] cmd_exp(input logic av, input logic pv,
		input logic [4:0] ctl);
		return {1'b1, av, pv, ctl};
	endfunction
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait on proximity busy, or on either channel when both set
	task automatic wait_on(input logic lvl, input logic both);
		c = 0;
		while ((both ? (amb_b | prox_b) : prox_b) !== lvl && c < 300) begin
			@(posedge mclk);
			#1;
			c++;
		end
		if (c == 300) begin
			mismatches++;
			end_of_test();
		end
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		i_lpm_host.rd(8'h80, d);
		`CHK("cmd", cmd_exp(0, 0, 5'h00), d)
		i_lpm_host.wr(8'h81, 8'hAC);
		i_lpm_host.wr(8'h80, 8'hE0);
		i_lpm_host.rd(8'h81, d);
		`CHK("id", 8'h53, d)
		i_lpm_host.rd(8'h80, d);
		`CHK("cmd ro", cmd_exp(0, 0, 5'h00), d)
		i_lpm_host.rd(8'h90, d);
		`CHK("unmapped", 8'h00, d)
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			@(posedge mclk);
			prox_s <= 16'($random(seed));
			amb_s <= 16'($random(seed));
			avg <= 3'($random(seed) & 3);
			m = (i == 0) ? 8'h08 : (i == 1) ? 8'h10 : 8'h18;
			i_lpm_host.wr(8'h80, m);
			i_lpm_host.rd(8'h80, d);
			`CHK("pending", cmd_exp(0, 0, m[4:0]), d)
			`CHK("busy", m[4:3], {amb_b, prox_b})
			wait_on(1'b0, 1'b1);
			i_lpm_host.rd(8'h80, d);
			`CHK("flags", cmd_exp(m[4], m[3], 5'h00), d)
			if (m[3]) begin
				`CHK("prox out", prox_s, prox_r)
				i_lpm_host.rd(8'h88, d);
				`CHK("prox lo", prox_s[7:0], d)
				i_lpm_host.rd(8'h87, d);
				`CHK("prox hi", prox_s[15:8], d)
			end
			if (m[4]) begin
				`CHK("amb out", amb_s, amb_r)
				i_lpm_host.rd(8'h85, d);
				`CHK("amb hi", amb_s[15:8], d)
				i_lpm_host.rd(8'h86, d);
				`CHK("amb lo", amb_s[7:0], d)
			end
			i_lpm_host.rd(8'h80, d);
			`CHK("cleared", cmd_exp(0, 0, 5'h00), d)
		end
		$display("test on-demand done");
		i_lpm_host.wr(8'h80, 8'h19);
		seen = 1'b0;
		repeat (40) begin
			@(posedge mclk);
			#1;
			seen = seen | amb_b | prox_b;
		end
		`CHK("osc", 1'b1, osc)
		`CHK("idle", 1'b0, seen)
		i_lpm_host.rd(8'h80, d);
		`CHK("ignored", cmd_exp(0, 0, 5'h01), d)
		i_lpm_host.wr(8'h80, 8'h00);
		i_lpm_host.wr(8'h82, 8'h02);
		i_lpm_host.wr(8'h80, 8'h01);
		i_lpm_host.wr(8'h80, 8'h03);
		wait_on(1'b1, 1'b0);
		wait_on(1'b0, 1'b0);
		p = c;
		wait_on(1'b1, 1'b0);
		`CHK("period", 64 >> 2, p + c)
		i_lpm_host.wr(8'h80, 8'h00);
		for (i = 0; i < 6; i++) begin
			i_lpm_host.gap = i % 3;
			m = 8'($random(seed));
			i_lpm_host.wr(8'h82, m);
			i_lpm_host.rd(8'h82, d);
			`CHK("rate", {5'h00, m[2:0]}, d)
		end
		// periodic ambient stream, self-timed set in the same write
		i_lpm_host.wr(8'h80, 8'h05);
		wait_on(1'b1, 1'b1);
		wait_on(1'b0, 1'b1);
		p = c;
		wait_on(1'b1, 1'b1);
		`CHK("amb period", 40, p + c)
		i_lpm_host.rd(8'h80, d);
		`CHK("timed flags", cmd_exp(1, 1, 5'h05), d)
		i_lpm_host.wr(8'h80, 8'h00);
		$display("test timed and rate done");
		end_of_test();
	end
endmodule // lpm_ctrl_tb_top
